// ==== design/rmhl_consts.svh ====
`ifndef RMHL_CONSTS_SVH
`define RMHL_CONSTS_SVH

// Clock and timing
`define RMHL_CLK_HZ 100000000
`define RMHL_TICK_HZ 1000
`define RMHL_BAUD_CABLE 19200
`define RMHL_BAUD_DIRECT 9600
`define RMHL_LOCK_TIMEOUT_S 5
`define RMHL_PROBE_GAP_MS 50
`define RMHL_BAUD_W 14
`define RMHL_TICK_W 17
`define RMHL_MS_W 13
`define RMHL_GAP_W 8

// Link control characters
`define RMHL_CH_STX 8'h02
`define RMHL_CH_ETX 8'h03
`define RMHL_CH_ACK 8'h06
`define RMHL_CH_CR 8'h0D
`define RMHL_CH_DIGIT0 8'h30
`define RMHL_CH_LETTER 8'h37

// Frame layout: last byte index of each frame kind
`define RMHL_PROBE_LAST 4'h1
`define RMHL_DATA_LAST 4'h9

// Record store
`define RMHL_REC_DEPTH 2016
`define RMHL_REC_AW 11

// Register offsets
`define RMHL_OFF_CTRL 8'h00
`define RMHL_OFF_STATUS 8'h04
`define RMHL_OFF_REC_SEL 8'h08
`define RMHL_OFF_REC_DATA 8'h0C

// Field positions
`define RMHL_CTRL_MODE_LSB 0
`define RMHL_CTRL_IFACE_LSB 3
`define RMHL_CTRL_LOCK_BIT 5
`define RMHL_ST_POWERED_BIT 0
`define RMHL_ST_LOCKED_BIT 1
`define RMHL_ST_WAIT_BIT 2
`define RMHL_ST_XFER_BIT 3
`define RMHL_ST_COUNT_LSB 8

`endif

// ==== design/rmhl_pkg.sv ====
package rmhl_pkg;
  `include "rmhl_consts.svh"

  typedef enum logic [2:0] {
    MODE_STORE, MODE_LIVE, MODE_HSHAKE, MODE_XFER, MODE_KEY
  } rmhl_mode_e;

  typedef enum logic [1:0] {
    IF_CABLE, IF_WIRELESS, IF_KEYBOARD, IF_DIRECT
  } rmhl_iface_e;

  typedef enum logic [2:0] {
    HS_IDLE, HS_PROBE, HS_WAIT, HS_DATA, HS_WAIT2
  } rmhl_hs_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rmhl_reg_req_s;

  typedef struct packed {
    logic valid;
    logic isCr;
    logic [31:0] code;
  } rmhl_key_s;

  typedef struct packed {
    rmhl_mode_e mode;
    rmhl_iface_e iface;
    logic powered;
    logic locked;
    rmhl_hs_e hs;
    logic ackMode;
    logic [31:0] code;
    logic [3:0] byteIdx;
    logic txBusy;
    logic [`RMHL_BAUD_W-1:0] txCnt;
    logic [3:0] txBit;
    logic [8:0] txShift;
    logic txd;
    logic [`RMHL_TICK_W-1:0] tickCnt;
    logic [`RMHL_MS_W-1:0] idleMs;
    logic [`RMHL_GAP_W-1:0] gapMs;
    logic [2:0] btnS1;
    logic [2:0] btnS2;
    logic [2:0] btnPrev;
    logic rxS1;
    logic rxS2;
    logic rxBusy;
    logic [`RMHL_BAUD_W-1:0] rxCnt;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic [15:0] rxHist;
    logic [`RMHL_REC_AW-1:0] recCount;
    logic [`RMHL_REC_AW-1:0] recSel;
    logic [31:0] rdData;
    logic wirelessDrop;
    rmhl_key_s key;
  } rmhl_state_s;
endpackage

// ==== design/rmhl_rec_mem.sv ====
`timescale 1ns/1ps
`include "rmhl_consts.svh"
module rmhl_rec_mem (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wrEn,
  input wire logic [`RMHL_REC_AW-1:0] wrAddr,
  input wire logic [31:0] wrData,
  // Read side
  input wire logic [`RMHL_REC_AW-1:0] rdAddr,
  output logic [31:0] rdData
);
  logic [31:0] mem [`RMHL_REC_DEPTH];

  // Write port and registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // rmhl_rec_mem

// ==== design/rmhl_mode_link.sv ====
// Notes on behaviour
// - Storing mode writes each read code into the record store; code stops writing once 2016 records are held.
// - Live mode sends each code at once, stores nothing; no host, code lost.
// - Live mode survives power-off; resumes after power-on.
// - Live mode is left only by selecting another mode.
// - Handshake mode first sends an empty start/end probe, then waits.
// - Host acks probe; device sends start, record, end; host acks again.
// - Without an answer the probe is resent periodically.
// - Both arrows during the wait abandon and drop the pending code.
// - Record-transfer mode refuses reads; only record exchange.
// - Record-transfer ends by arrow chord or host end command.
// - Record-transfer mode inhibits automatic switch-off.
// - Cable link runs 19200 baud, 8 data, no parity, one stop.
// - Direct serial variant runs 9600 baud, 8 data, no parity, one stop.
// - Choosing cable tears down any wireless link.
// - Keyboard emulation delivers every read code as keystrokes.
// - Keyboard emulation forces keystroke mode, others unselectable.
// - In keyboard emulation a left press at idle sends carriage return.
// - Lock powers down at once; shows locked after next power-on.
// - While locked, reads and menu are blocked.
// - While locked, switch off after lock timeout with no button press.
// - Arrow chord clears the locked state.
// - Acknowledge character is 0x06.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rmhl_consts.svh"
module rmhl_mode_link #(
  parameter int TICK_CYC = `RMHL_CLK_HZ / `RMHL_TICK_HZ,
  parameter int LOCK_MS = `RMHL_LOCK_TIMEOUT_S * `RMHL_TICK_HZ,
  parameter int GAP_MS = `RMHL_PROBE_GAP_MS,
  parameter int BAUD_CAB_CYC = `RMHL_CLK_HZ / `RMHL_BAUD_CABLE,
  parameter int BAUD_DIR_CYC = `RMHL_CLK_HZ / `RMHL_BAUD_DIRECT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire rmhl_pkg::rmhl_reg_req_s regReq,
  output logic [31:0] regRdData,
  // Button pins
  input wire logic btnMain,
  input wire logic btnLeft,
  input wire logic btnRight,
  // Transponder reader
  input wire logic tagValid,
  input wire logic [31:0] tagCode,
  output logic readEnable,
  // Command engine
  input wire logic hostEndCmd,
  // Serial link
  input wire logic rxd,
  output logic txd,
  // System status
  output logic powerHold,
  output logic lockedInd,
  output logic menuEnable,
  output logic autoOffInhibit,
  output logic wirelessDrop,
  output logic waitingHost,
  // Keystroke output
  output rmhl_pkg::rmhl_key_s keyOut
);
  rmhl_pkg::rmhl_state_s s;
  rmhl_pkg::rmhl_state_s n;
  logic [31:0] memRd;
  logic memWr;
  logic tickEn;
  logic chord;
  logic ackSeen;
  logic menuOk;
  logic ctrlWr;
  logic [2:0] press;
  logic [`RMHL_BAUD_W-1:0] baudDiv;
  logic [3:0] lastIdx;

  // Nibble to ASCII hex digit
  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    return (nib < 4'hA) ? `RMHL_CH_DIGIT0 + {4'h0, nib}
                        : `RMHL_CH_LETTER + {4'h0, nib};
  endfunction

  // Byte at a position of a probe or data frame
  function automatic logic [7:0] frameByte(input logic probe,
      input logic [3:0] idx, input logic [31:0] code);
    logic [31:0] sh;
    sh = code << (5'(idx - 4'h1) << 2);
    if (idx == 4'h0) return `RMHL_CH_STX;
    if (probe || idx == `RMHL_DATA_LAST) return `RMHL_CH_ETX;
    return hexChar(sh[31:28]);
  endfunction

  // Record store
  rmhl_rec_mem u_mem (
    .clk(clk),
    .wrEn(memWr),
    .wrAddr(s.recCount),
    .wrData(tagCode),
    .rdAddr(s.recSel),
    .rdData(memRd)
  );

  // Outputs straight from state
  assign regRdData = s.rdData;
  assign txd = s.txd;
  assign powerHold = s.powered;
  assign lockedInd = s.locked & s.powered;
  assign menuOk = s.powered & ~s.locked;
  assign menuEnable = menuOk;
  assign autoOffInhibit = s.mode == rmhl_pkg::MODE_XFER;
  assign wirelessDrop = s.wirelessDrop;
  assign waitingHost = (s.hs == rmhl_pkg::HS_WAIT) ||
                       (s.hs == rmhl_pkg::HS_WAIT2);
  assign keyOut = s.key;
  assign readEnable = menuOk && s.mode != rmhl_pkg::MODE_XFER &&
                      s.hs == rmhl_pkg::HS_IDLE && !s.txBusy;
  assign ctrlWr = regReq.wr && regReq.addr == `RMHL_OFF_CTRL;

  // Next-state logic
  always_comb begin
    n = s;
    n.wirelessDrop = 1'b0;
    n.key.valid = 1'b0;
    n.key.isCr = 1'b0;
    n.rdData = 32'h0;
    memWr = 1'b0;
    ackSeen = 1'b0;
    // Pin synchronisers and edges
    n.btnS1 = {btnMain, btnLeft, btnRight};
    n.btnS2 = s.btnS1;
    n.rxS1 = rxd;
    n.rxS2 = s.rxS1;
    n.btnPrev = s.btnS2;
    press = s.btnS2 & ~s.btnPrev;
    chord = (&s.btnS2[1:0]) & ~(&s.btnPrev[1:0]);
    // Millisecond enable
    tickEn = s.tickCnt == `RMHL_TICK_W'(TICK_CYC - 1);
    n.tickCnt = tickEn ? '0 : s.tickCnt + `RMHL_TICK_W'(1);
    baudDiv = (s.iface == rmhl_pkg::IF_DIRECT)
      ? `RMHL_BAUD_W'(BAUD_DIR_CYC) : `RMHL_BAUD_W'(BAUD_CAB_CYC);
    lastIdx = (s.hs == rmhl_pkg::HS_DATA) ? `RMHL_DATA_LAST
                                          : `RMHL_PROBE_LAST;
    // Power-on by main button; mode and lock are retained
    if (!s.powered && press[2]) begin
      n.powered = 1'b1;
      n.idleMs = '0;
    end
    // Locked: time out without buttons, unlock by chord
    if (s.powered && s.locked) begin
      if (|press) begin
        n.idleMs = '0;
      end else if (tickEn) begin
        if (s.idleMs == `RMHL_MS_W'(LOCK_MS - 1)) begin
          n.powered = 1'b0;
          n.idleMs = '0;
        end else begin
          n.idleMs = s.idleMs + `RMHL_MS_W'(1);
        end
      end
      if (chord) begin
        n.locked = 1'b0;
      end
    end
    // Leaving record transfer
    if (s.mode == rmhl_pkg::MODE_XFER && menuOk && (chord || hostEndCmd)) begin
      n.mode = rmhl_pkg::MODE_STORE;
    end
    // Accepted reads, by mode
    if (tagValid && readEnable) begin
      case (s.mode)
        rmhl_pkg::MODE_STORE: begin
          if (s.recCount < `RMHL_REC_AW'(`RMHL_REC_DEPTH)) begin
            memWr = 1'b1;
            n.recCount = s.recCount + `RMHL_REC_AW'(1);
          end
        end
        rmhl_pkg::MODE_LIVE: begin
          n.code = tagCode;
          n.ackMode = 1'b0;
          n.byteIdx = 4'h0;
          n.hs = rmhl_pkg::HS_DATA;
        end
        rmhl_pkg::MODE_HSHAKE: begin
          n.code = tagCode;
          n.ackMode = 1'b1;
          n.byteIdx = 4'h0;
          n.hs = rmhl_pkg::HS_PROBE;
        end
        rmhl_pkg::MODE_KEY: begin
          n.key.valid = 1'b1;
          n.key.code = tagCode;
        end
        default: begin
        end
      endcase
    end
    // Carriage return key at idle
    if (s.mode == rmhl_pkg::MODE_KEY && menuOk && press[1] &&
        s.hs == rmhl_pkg::HS_IDLE) begin
      n.key.valid = 1'b1;
      n.key.isCr = 1'b1;
      n.key.code = {24'h0, `RMHL_CH_CR};
    end
    // Serial receiver and answer detection
    if (!s.rxBusy) begin
      if (!s.rxS2) begin
        n.rxBusy = 1'b1;
        n.rxCnt = baudDiv >> 1;
        n.rxBit = 4'h0;
      end
    end else if (s.rxCnt != '0) begin
      n.rxCnt = s.rxCnt - `RMHL_BAUD_W'(1);
    end else begin
      n.rxCnt = baudDiv - `RMHL_BAUD_W'(1);
      if (s.rxBit == 4'h0) begin
        n.rxBusy = !s.rxS2;
        n.rxBit = 4'h1;
      end else if (s.rxBit < 4'h9) begin
        n.rxShift = {s.rxS2, s.rxShift[7:1]};
        n.rxBit = s.rxBit + 4'h1;
      end else begin
        n.rxBusy = 1'b0;
        if (s.rxS2) begin
          n.rxHist = {s.rxHist[7:0], s.rxShift};
          ackSeen = s.rxShift == `RMHL_CH_ETX &&
            s.rxHist == {`RMHL_CH_STX, `RMHL_CH_ACK};
        end
      end
    end
    // Serial transmitter, 8N1
    if (s.txBusy) begin
      if (s.txCnt == baudDiv - `RMHL_BAUD_W'(1)) begin
        n.txCnt = '0;
        if (s.txBit == 4'h0) begin
          n.txBusy = 1'b0;
        end else begin
          n.txd = s.txShift[0];
          n.txShift = {1'b1, s.txShift[8:1]};
          n.txBit = s.txBit - 4'h1;
        end
      end else begin
        n.txCnt = s.txCnt + `RMHL_BAUD_W'(1);
      end
    end
    // Handshake sequencer
    case (s.hs)
      rmhl_pkg::HS_PROBE, rmhl_pkg::HS_DATA: begin
        if (!s.txBusy) begin
          if (s.byteIdx > lastIdx) begin
            n.byteIdx = 4'h0;
            n.gapMs = '0;
            if (s.hs == rmhl_pkg::HS_PROBE) begin
              n.hs = rmhl_pkg::HS_WAIT;
            end else begin
              n.hs = s.ackMode ? rmhl_pkg::HS_WAIT2 : rmhl_pkg::HS_IDLE;
            end
          end else begin
            n.txBusy = 1'b1;
            n.txCnt = '0;
            n.txd = 1'b0;
            n.txBit = 4'h9;
            n.txShift = {1'b1, frameByte(s.hs == rmhl_pkg::HS_PROBE,
                                         s.byteIdx, s.code)};
            n.byteIdx = s.byteIdx + 4'h1;
          end
        end
      end
      rmhl_pkg::HS_WAIT: begin
        if (ackSeen) begin
          n.hs = rmhl_pkg::HS_DATA;
        end else if (chord) begin
          n.hs = rmhl_pkg::HS_IDLE;
        end else if (tickEn) begin
          if (s.gapMs == `RMHL_GAP_W'(GAP_MS - 1)) begin
            n.hs = rmhl_pkg::HS_PROBE;
          end else begin
            n.gapMs = s.gapMs + `RMHL_GAP_W'(1);
          end
        end
      end
      rmhl_pkg::HS_WAIT2: begin
        if (ackSeen || chord) begin
          n.hs = rmhl_pkg::HS_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Register writes
    if (ctrlWr && menuOk) begin
      n.iface = rmhl_pkg::rmhl_iface_e'(
        regReq.wdata[`RMHL_CTRL_IFACE_LSB +: 2]);
      if (n.iface != rmhl_pkg::IF_WIRELESS) begin
        n.wirelessDrop = 1'b1;
      end
      if (n.iface == rmhl_pkg::IF_KEYBOARD) begin
        n.mode = rmhl_pkg::MODE_KEY;
      end else if (regReq.wdata[`RMHL_CTRL_MODE_LSB +: 3] <= 3'(
          rmhl_pkg::MODE_XFER)) begin
        n.mode = rmhl_pkg::rmhl_mode_e'(
          regReq.wdata[`RMHL_CTRL_MODE_LSB +: 3]);
      end else begin
        n.mode = rmhl_pkg::MODE_STORE;
      end
      if (n.mode != s.mode) begin
        n.hs = rmhl_pkg::HS_IDLE;
      end
      if (regReq.wdata[`RMHL_CTRL_LOCK_BIT]) begin
        n.locked = 1'b1;
        n.powered = 1'b0;
      end
    end
    if (regReq.wr && regReq.addr == `RMHL_OFF_REC_SEL) begin
      n.recSel = regReq.wdata[`RMHL_REC_AW-1:0];
    end
    // Register reads
    if (regReq.rd) begin
      case (regReq.addr)
        `RMHL_OFF_CTRL: begin
          n.rdData[`RMHL_CTRL_MODE_LSB +: 3] = s.mode;
          n.rdData[`RMHL_CTRL_IFACE_LSB +: 2] = s.iface;
        end
        `RMHL_OFF_STATUS: begin
          n.rdData[`RMHL_ST_POWERED_BIT] = s.powered;
          n.rdData[`RMHL_ST_LOCKED_BIT] = s.locked;
          n.rdData[`RMHL_ST_WAIT_BIT] = waitingHost;
          n.rdData[`RMHL_ST_XFER_BIT] = autoOffInhibit;
          n.rdData[`RMHL_ST_COUNT_LSB +: `RMHL_REC_AW] = s.recCount;
        end
        `RMHL_OFF_REC_SEL: n.rdData[`RMHL_REC_AW-1:0] = s.recSel;
        `RMHL_OFF_REC_DATA: n.rdData = memRd;
        default: n.rdData = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.mode <= rmhl_pkg::MODE_STORE;
      s.iface <= rmhl_pkg::IF_CABLE;
      s.hs <= rmhl_pkg::HS_IDLE;
      s.powered <= 1'b1;
      s.txd <= 1'b1;
      s.txShift <= 9'h1FF;
      s.rxS1 <= 1'b1;
      s.rxS2 <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_store;
    (s.mode == rmhl_pkg::MODE_STORE && tagValid && readEnable &&
     s.recCount < 11'(`RMHL_REC_DEPTH)) |=>
      s.recCount == $past(s.recCount) + 11'h1;
  endproperty
  a_store: assert property (p_store) else $error("read not stored");

  property p_live;
    (s.mode == rmhl_pkg::MODE_LIVE && tagValid && readEnable && !ctrlWr) |=>
      (s.hs == rmhl_pkg::HS_DATA && s.recCount == $past(s.recCount));
  endproperty
  a_live: assert property (p_live) else $error("live read wrong");

  property p_probe;
    (s.mode == rmhl_pkg::MODE_HSHAKE && tagValid && readEnable &&
     !ctrlWr) |=>
      s.hs == rmhl_pkg::HS_PROBE ##1 (s.txBusy && !s.txd);
  endproperty
  a_probe: assert property (p_probe) else $error("no probe start");

  property p_resend;
    (s.hs == rmhl_pkg::HS_WAIT && tickEn && !ackSeen && !chord &&
     !ctrlWr && s.gapMs == 8'(GAP_MS - 1)) |=> s.hs == rmhl_pkg::HS_PROBE;
  endproperty
  a_resend: assert property (p_resend) else $error("probe not resent");

  property p_abandon;
    (s.hs == rmhl_pkg::HS_WAIT && chord && !ackSeen) |=>
      s.hs == rmhl_pkg::HS_IDLE;
  endproperty
  a_abandon: assert property (p_abandon) else $error("wait not left");

  property p_xfer;
    s.mode == rmhl_pkg::MODE_XFER |-> !readEnable && autoOffInhibit;
  endproperty
  a_xfer: assert property (p_xfer) else $error("read in transfer");

  property p_kbd;
    s.iface == rmhl_pkg::IF_KEYBOARD |-> s.mode == rmhl_pkg::MODE_KEY;
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard mode lost");

  property p_lock;
    (ctrlWr && menuOk && regReq.wdata[`RMHL_CTRL_LOCK_BIT]) |=>
      (!s.powered && s.locked && !lockedInd);
  endproperty
  a_lock: assert property (p_lock) else $error("lock no power-off");

  property p_blocked;
    s.locked |-> !readEnable && !menuEnable;
  endproperty
  a_blocked: assert property (p_blocked) else $error("locked not blocked");

  property p_unlock;
    (s.locked && s.powered && chord && !ctrlWr) |=> !s.locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("chord no unlock");
endmodule // rmhl_mode_link

// ==== tb/rmhl_host_model.sv ====
`timescale 1ns/1ps
// Host end of the serial link: decodes bytes, optionally answers frames
module rmhl_host_model (
  // Clock
  input wire logic clk,
  // Link lines
  input wire logic txd,
  output logic rxd,
  // Behaviour controls
  input wire logic [15:0] bitCyc,
  input wire logic ackEn
);
  logic [7:0] got[$];
  event sendAck;

  initial rxd = 1'b1;

  // Receiver, 8N1 LSB first, mid-bit sampling
  always begin : rxProc
    logic [7:0] b;
    @(negedge txd);
    repeat (bitCyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(posedge clk);
      b[i] = txd;
    end
    repeat (bitCyc) @(posedge clk);
    got.push_back(b);
    if (ackEn && b == 8'h03) ->sendAck;
  end

  // One byte out, start bit first, then idle high
  task automatic sendByte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bitCyc) @(posedge clk);
    end
  endtask

  // Answer frame after each received end character while ackEn is high
  always begin
    @(sendAck);
    repeat (2 * bitCyc) @(posedge clk);
    sendByte(8'h02);
    sendByte(8'h06);
    sendByte(8'h03);
  end
endmodule // rmhl_host_model

// ==== tb/rmhl_mode_link_tb.sv ====
`timescale 1ns/1ps
module rmhl_mode_link_tb;
  typedef struct packed {
    logic [31:0] wdata;
    logic [31:0] ctrl;
    logic inhibit;
    logic drop;
  } rmhl_row_s;
  logic clk;
  logic resetn;
  rmhl_pkg::rmhl_reg_req_s regReq;
  logic [31:0] regRdData;
  logic btnMain, btnLeft, btnRight, tagValid, hostEndCmd, rxd, txd;
  logic [31:0] tagCode;
  logic readEnable, powerHold, lockedInd, menuEnable;
  logic autoOffInhibit, wirelessDrop, waitingHost, ackEn;
  logic [15:0] bitCyc;
  rmhl_pkg::rmhl_key_s keyOut;
  rmhl_pkg::rmhl_key_s lastKey;
  int errTotal = 0;
  int samplesChecked = 0;
  int keyCnt = 0;
  int n;
  logic [31:0] rd;
  logic [31:0] cnt0;
  rmhl_row_s rows [8] = '{
    '{32'h01, 32'h01, 1'b0, 1'b1}, '{32'h02, 32'h02, 1'b0, 1'b1},
    '{32'h03, 32'h03, 1'b1, 1'b1}, '{32'h08, 32'h08, 1'b0, 1'b0},
    '{32'h05, 32'h00, 1'b0, 1'b1}, '{32'h11, 32'h14, 1'b0, 1'b1},
    '{32'h19, 32'h19, 1'b0, 1'b1}, '{32'h00, 32'h00, 1'b0, 1'b1}};

  // Probe gap kept at full length so a host answer lands inside the wait
  rmhl_mode_link #(.TICK_CYC(10), .LOCK_MS(5),
    .BAUD_CAB_CYC(8), .BAUD_DIR_CYC(16)) u_dut (
    .clk(clk), .resetn(resetn), .regReq(regReq), .regRdData(regRdData),
    .btnMain(btnMain), .btnLeft(btnLeft), .btnRight(btnRight),
    .tagValid(tagValid), .tagCode(tagCode), .readEnable(readEnable),
    .hostEndCmd(hostEndCmd), .rxd(rxd), .txd(txd), .powerHold(powerHold),
    .lockedInd(lockedInd), .menuEnable(menuEnable),
    .autoOffInhibit(autoOffInhibit), .wirelessDrop(wirelessDrop),
    .waitingHost(waitingHost), .keyOut(keyOut));
  rmhl_host_model u_host (.clk(clk), .txd(txd), .rxd(rxd), .bitCyc(bitCyc),
    .ackEn(ackEn));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Keystroke capture
  always @(posedge clk) begin
    if (keyOut.valid === 1'b1) begin
      lastKey <= keyOut;
      keyCnt <= keyCnt + 1;
    end
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    errTotal++;
    conclude();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bus cycles, each returns one edge after the taken edge
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
    @(posedge clk);
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    @(posedge clk);
    d = regRdData;
  endtask

  task automatic tag(input logic [31:0] c);
    tagValid <= 1'b1;
    tagCode <= c;
    @(posedge clk);
    tagValid <= 1'b0;
    @(posedge clk);
  endtask

  // Buttons as {main, left, right}
  task automatic press(input logic [2:0] m);
    {btnMain, btnLeft, btnRight} <= m;
    repeat (6) @(posedge clk);
    {btnMain, btnLeft, btnRight} <= 3'b000;
    repeat (6) @(posedge clk);
  endtask

  task automatic waitFor(ref logic s, input logic v);
    for (int i = 0; i < 3000 && s !== v; i++) @(posedge clk);
  endtask

  task automatic waitBytes(input int k);
    for (int i = 0; i < 20000 && u_host.got.size() < k; i++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask

  function automatic logic [7:0] hexCh(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
  endfunction

  // Data frame: start, eight hex digits high nibble first, end
  task automatic chkFrame(input logic [31:0] c, input int skip);
    logic [7:0] e[$];
    e = {8'h02};
    for (int i = 7; i >= 0; i--) e.push_back(hexCh(c[4*i +: 4]));
    e.push_back(8'h03);
    chk(u_host.got.size(), e.size() + skip);
    for (int i = 0; i < e.size(); i++) chk(u_host.got[skip + i], e[i]);
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    regReq = '0;
    {btnMain, btnLeft, btnRight, tagValid, hostEndCmd, ackEn} = 6'h00;
    tagCode = 32'h0;
    bitCyc = 16'h0008;
    repeat (20) @(posedge clk);
    chk({txd, powerHold, readEnable, menuEnable, lockedInd, waitingHost,
      autoOffInhibit, wirelessDrop}, 32'hF0);
    resetn <= 1'b1;
    @(posedge clk);
    // Table of mode and interface writes
    foreach (rows[i]) begin
      wrReg(8'h00, rows[i].wdata);
      chk(wirelessDrop, rows[i].drop);
      chk(autoOffInhibit, rows[i].inhibit);
      rdReg(8'h00, rd);
      chk(rd, rows[i].ctrl);
    end
    rdReg(8'h10, rd);
    chk(rd, 32'h0);
    // Storing
    rdReg(8'h04, cnt0);
    tag(32'h4C8C1C84);
    rdReg(8'h04, rd);
    chk(rd[18:8], cnt0[18:8] + 11'h001);
    wrReg(8'h08, 32'h0);
    rdReg(8'h0C, rd);
    chk(rd, 32'h4C8C1C84);
    // Live on cable, then on direct serial
    wrReg(8'h00, 32'h01);
    u_host.got.delete();
    tag(32'h4C8C1C84);
    waitBytes(10);
    chkFrame(32'h4C8C1C84, 0);
    rdReg(8'h04, rd);
    chk(rd[18:8], cnt0[18:8] + 11'h001);
    wrReg(8'h00, 32'h19);
    bitCyc <= 16'h0010;
    u_host.got.delete();
    tag(32'h0123ABEF);
    waitBytes(10);
    chkFrame(32'h0123ABEF, 0);
    bitCyc <= 16'h0008;
    // Handshake with answering host
    wrReg(8'h00, 32'h02);
    ackEn <= 1'b1;
    u_host.got.delete();
    tag(32'hFEDC0987);
    waitBytes(12);
    waitFor(readEnable, 1'b1);
    chk(u_host.got[0], 32'h02);
    chk(u_host.got[1], 32'h03);
    chkFrame(32'hFEDC0987, 2);
    chk(readEnable, 1'b1);
    // Handshake with silent host, then arrow chord
    ackEn <= 1'b0;
    u_host.got.delete();
    tag(32'h11112222);
    waitBytes(4);
    waitFor(waitingHost, 1'b1);
    for (int i = 0; i < 4; i++) chk(u_host.got[i], 32'h02 + i % 2);
    press(3'b011);
    chk(waitingHost, 1'b0);
    repeat (400) @(posedge clk);
    n = 0;
    foreach (u_host.got[i]) n += (u_host.got[i] > 8'h03);
    chk(n, 0);
    chk(readEnable, 1'b1);
    // Record transfer
    wrReg(8'h00, 32'h03);
    chk(readEnable, 1'b0);
    rdReg(8'h04, cnt0);
    tag(32'h00000005);
    rdReg(8'h04, rd);
    chk(rd[18:8], cnt0[18:8]);
    hostEndCmd <= 1'b1;
    @(posedge clk);
    hostEndCmd <= 1'b0;
    @(posedge clk);
    rdReg(8'h00, rd);
    chk(rd, 32'h0);
    wrReg(8'h00, 32'h03);
    press(3'b011);
    rdReg(8'h00, rd);
    chk(rd, 32'h0);
    chk(autoOffInhibit, 1'b0);
    // Keystroke output
    wrReg(8'h00, 32'h10);
    tag(32'hCAFE0001);
    repeat (2) @(posedge clk);
    chk(keyCnt, 1);
    chk(lastKey.code, 32'hCAFE0001);
    press(3'b010);
    chk(keyCnt, 2);
    chk(lastKey.isCr, 1'b1);
    chk(lastKey.code, 32'h0000000D);
    // Lock, power cycle, unlock
    wrReg(8'h00, 32'h01);
    wrReg(8'h00, 32'h21);
    chk(powerHold, 1'b0);
    press(3'b100);
    chk({powerHold, lockedInd, menuEnable, readEnable}, 4'hC);
    wrReg(8'h00, 32'h02);
    for (n = 0; n < 300 && powerHold === 1'b1; n++) @(posedge clk);
    chk(n >= 25 && n <= 70, 1'b1);
    press(3'b100);
    press(3'b011);
    chk({lockedInd, menuEnable}, 2'b01);
    rdReg(8'h00, rd);
    chk(rd, 32'h01);
    conclude();
  end
endmodule // rmhl_mode_link_tb
